// ---- hw/mfirq_pkg.sv ----
`default_nettype none

package mfirq_pkg;

  localparam int N_SRC   = 14;
  localparam int N_GRP   = 4;
  localparam int N_OVP   = 4;
  localparam int N_TMEV  = 4;
  localparam int ADDR_W  = 6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SRC_FLAG  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SRC_EN    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_GRP_CTRL  = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PSC_SEL   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_TBA_CTRL  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_TBB_CTRL  = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 6'h1c;

  // source flag positions
  localparam int SRC_OVP0    = 0;
  localparam int SRC_JIT_OVF = 4;
  localparam int SRC_APPR    = 5;
  localparam int SRC_TM0     = 6;
  localparam int SRC_PWM_PER = 10;
  localparam int SRC_PWM_DTY = 11;
  localparam int SRC_TBA     = 12;
  localparam int SRC_TBB     = 13;

  // group control register fields
  localparam int GC_EN_LSB   = 0;
  localparam int GC_FLAG_LSB = 4;
  localparam int GC_GIE_BIT  = 8;

  // time base control fields
  localparam int TB_ON_BIT   = 7;
  localparam int TB_PER_W    = 3;
  localparam int TB_MIN_EXP  = 8;
  localparam int TB_CNT_W    = 15;

  localparam int PSC_SEL_W   = 2;
  localparam logic [1:0] PSC_DIV4_LAST = 2'h3;

  // group membership
  localparam logic [N_SRC-1:0] GRP_MASK [N_GRP] = '{
    14'h000f,  // over-voltage channels
    14'h0030,  // jitter overflow, approach match
    14'h03c0,  // timer module matches
    14'h3c00   // pwm and time bases
  };

  // reset values
  localparam logic [N_SRC-1:0] SRC_RST  = 14'h0000;
  localparam logic [7:0]       REG8_RST = 8'h00;
  localparam logic [N_GRP-1:0] GRP_RST  = 4'h0;

  typedef enum logic [1:0] {
    PSC_SYS  = 2'b00,
    PSC_DIV4 = 2'b01,
    PSC_SUB  = 2'b10,
    PSC_SUB2 = 2'b11
  } mfirq_psc_e;

endpackage

`default_nettype wire

// ---- hw/mfirq_tb_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module mfirq_tb_div
  import mfirq_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                tick,
  input  wire logic                enable,
  input  wire logic [TB_PER_W-1:0] period_sel,
  output logic                     overflow
);

  logic [TB_CNT_W-1:0] cnt_q;

  // all-ones mask of the low 2^(8+sel) count
  function automatic logic [TB_CNT_W-1:0] span_mask(input logic [TB_PER_W-1:0] sel);
    logic [TB_CNT_W:0] one;
    one = {{TB_CNT_W{1'b0}}, 1'b1};
    span_mask = TB_CNT_W'((one << (TB_MIN_EXP + int'(sel))) - 1'b1);
  endfunction

  // disabled divider restarts from zero so the first period is whole
  always_ff @(posedge clk_sys) begin
    if (rst || !enable) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= enable && tick &&
                  ((cnt_q & span_mask(period_sel)) == span_mask(period_sel));
    end
  end

endmodule

`default_nettype wire

// ---- hw/mfirq_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - over-voltage channel flag sets while its comparator reports input above threshold
// - vector request needs global, source and group enables, and stack not full
// - servicing clears global enable and group flag; over-voltage flag stays
// - jitter counter overflow sets the jitter overflow flag
// - jitter overflow flag survives servicing; software clears it
// - finished approach of period or dead time to target sets approach flag
// - approach flag survives servicing; software clears it
// - each timer module has comparator A and P match flags, each enabled
// - timer match flags survive servicing; software clears them
// - pwm period match and duty match set separate enabled flags
// - pwm servicing clears the group flag and global enable, not the pwm source flags
// - each time base divider overflow sets its flag periodically
// - time base flags survive servicing; software clears them
// - prescaler source: 00 system, 01 system over four, 1x subsidiary clock
// - prescaler select holds two low bits, reset zero, upper bits read zero
// - prescaler clock feeds each time base divider, ratio from its control
// - group flag sets whenever a member source flag becomes set
// - time base has enable and 3-bit period, 2^8 to 2^15 ticks
module mfirq_top
  import mfirq_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]      avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  // event sources
  input  wire logic [N_OVP-1:0]       overvolt_cmp,
  input  wire logic                   jitter_counter_ovf,
  input  wire logic                   approach_done,
  input  wire logic [N_TMEV-1:0]      tm_match,
  input  wire logic                   pwm_period_match,
  input  wire logic                   pwm_duty_match,
  input  wire logic                   subsidiary_clock,
  // core interface
  input  wire logic                   stack_full,
  input  wire logic                   vector_ack,
  input  wire logic                   return_enable,
  output logic                        vector_req,
  output logic [1:0]                  vector_group,
  output logic                        irq
);

  logic [N_SRC-1:0]     src_flag_q;
  logic [N_SRC-1:0]     src_flag_d;
  logic [N_SRC-1:0]     src_en_q;
  logic [N_GRP-1:0]     grp_en_q;
  logic [N_GRP-1:0]     grp_flag_q;
  logic [N_GRP-1:0]     grp_flag_d;
  logic [N_GRP-1:0]     grp_set;
  logic [N_GRP-1:0]     grp_pend;
  logic                 gie_q;
  logic [PSC_SEL_W-1:0] psc_sel_q;
  logic [7:0]           tba_ctrl_q;
  logic [7:0]           tbb_ctrl_q;
  logic [N_GRP-1:0]     stat_q;
  logic [N_GRP-1:0]     mask_q;
  logic                 ack_q;
  logic                 wr_go;
  logic                 rd_go;
  logic [31:0]          rd_mux;
  logic [N_OVP-1:0]     ovp_s1_q;
  logic [N_OVP-1:0]     ovp_s2_q;
  logic                 sub_s1_q;
  logic                 sub_s2_q;
  logic                 sub_s3_q;
  logic [1:0]           div4_q;
  logic                 psc_tick;
  logic                 tba_ovf;
  logic                 tbb_ovf;
  logic [N_SRC-1:0]     src_ev;
  logic [1:0]           sel_grp;

  // avalon handshake: one wait cycle, completion on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign rd_go = avs_read && ack_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  function automatic logic reg_hit(input logic [ADDR_W-1:0] ofs);
    reg_hit = (avs_address[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // only the low byte lane carries narrow fields; wider ones use two lanes
  function automatic logic lane_ok(input int lane);
    lane_ok = avs_byteenable[lane];
  endfunction

  // read mux, unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_hit(OFS_SRC_FLAG)) begin
      rd_mux[N_SRC-1:0] = src_flag_q;
    end else if (reg_hit(OFS_SRC_EN)) begin
      rd_mux[N_SRC-1:0] = src_en_q;
    end else if (reg_hit(OFS_GRP_CTRL)) begin
      rd_mux[GC_EN_LSB +: N_GRP]   = grp_en_q;
      rd_mux[GC_FLAG_LSB +: N_GRP] = grp_flag_q;
      rd_mux[GC_GIE_BIT]           = gie_q;
    end else if (reg_hit(OFS_PSC_SEL)) begin
      rd_mux[PSC_SEL_W-1:0] = psc_sel_q;
    end else if (reg_hit(OFS_TBA_CTRL)) begin
      rd_mux[7:0] = tba_ctrl_q;
    end else if (reg_hit(OFS_TBB_CTRL)) begin
      rd_mux[7:0] = tbb_ctrl_q;
    end else if (reg_hit(OFS_IRQ_STAT)) begin
      rd_mux[N_GRP-1:0] = stat_q | grp_set;
    end else if (reg_hit(OFS_IRQ_MASK)) begin
      rd_mux[N_GRP-1:0] = mask_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

  // comparator and subsidiary clock come from outside this domain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovp_s1_q <= '0;
      ovp_s2_q <= '0;
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      ovp_s1_q <= overvolt_cmp;
      ovp_s2_q <= ovp_s1_q;
      sub_s1_q <= subsidiary_clock;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  // prescaler clock as a one-cycle enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 1'b1;
    end
  end

  always_comb begin
    case (mfirq_psc_e'(psc_sel_q))
      PSC_SYS:  psc_tick = 1'b1;
      PSC_DIV4: psc_tick = (div4_q == PSC_DIV4_LAST);
      PSC_SUB:  psc_tick = sub_s2_q && !sub_s3_q;
      PSC_SUB2: psc_tick = sub_s2_q && !sub_s3_q;
      default:  psc_tick = 1'b0;
    endcase
  end

  mfirq_tb_div u_tba (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .tick       (psc_tick),
    .enable     (tba_ctrl_q[TB_ON_BIT]),
    .period_sel (tba_ctrl_q[TB_PER_W-1:0]),
    .overflow   (tba_ovf)
  );

  mfirq_tb_div u_tbb (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .tick       (psc_tick),
    .enable     (tbb_ctrl_q[TB_ON_BIT]),
    .period_sel (tbb_ctrl_q[TB_PER_W-1:0]),
    .overflow   (tbb_ovf)
  );

  // event vector in flag order
  always_comb begin
    src_ev = '0;
    src_ev[SRC_OVP0 +: N_OVP] = ovp_s2_q;
    src_ev[SRC_JIT_OVF]       = jitter_counter_ovf;
    src_ev[SRC_APPR]          = approach_done;
    src_ev[SRC_TM0 +: N_TMEV] = tm_match;
    src_ev[SRC_PWM_PER]       = pwm_period_match;
    src_ev[SRC_PWM_DTY]       = pwm_duty_match;
    src_ev[SRC_TBA]           = tba_ovf;
    src_ev[SRC_TBB]           = tbb_ovf;
  end

  // software write first, then events on top: a set beats a clear
  always_comb begin
    src_flag_d = src_flag_q;
    if (wr_go && reg_hit(OFS_SRC_FLAG)) begin
      if (lane_ok(0)) begin
        src_flag_d[7:0] = avs_writedata[7:0];
      end
      if (lane_ok(1)) begin
        src_flag_d[N_SRC-1:8] = avs_writedata[N_SRC-1:8];
      end
    end
    src_flag_d = src_flag_d | src_ev;
  end

  // servicing never touches source flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_flag_q <= SRC_RST;
    end else begin
      src_flag_q <= src_flag_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_en_q <= SRC_RST;
    end else if (wr_go && reg_hit(OFS_SRC_EN)) begin
      if (lane_ok(0)) begin
        src_en_q[7:0] <= avs_writedata[7:0];
      end
      if (lane_ok(1)) begin
        src_en_q[N_SRC-1:8] <= avs_writedata[N_SRC-1:8];
      end
    end
  end

  // group set on a member flag rising
  always_comb begin
    for (int g = 0; g < N_GRP; g++) begin
      grp_set[g] = |(src_flag_d & ~src_flag_q & GRP_MASK[g]);
    end
  end

  always_comb begin
    grp_flag_d = grp_flag_q;
    if (wr_go && reg_hit(OFS_GRP_CTRL) && lane_ok(0)) begin
      grp_flag_d = avs_writedata[GC_FLAG_LSB +: N_GRP];
    end
    if (vector_ack) begin
      grp_flag_d[vector_group] = 1'b0;
    end
    grp_flag_d = grp_flag_d | grp_set;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      grp_flag_q <= GRP_RST;
    end else begin
      grp_flag_q <= grp_flag_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      grp_en_q <= GRP_RST;
    end else if (wr_go && reg_hit(OFS_GRP_CTRL) && lane_ok(0)) begin
      grp_en_q <= avs_writedata[GC_EN_LSB +: N_GRP];
    end
  end

  // ack beats a simultaneous return, so nesting stays closed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gie_q <= 1'b0;
    end else if (vector_ack) begin
      gie_q <= 1'b0;
    end else if (return_enable) begin
      gie_q <= 1'b1;
    end else if (wr_go && reg_hit(OFS_GRP_CTRL) && lane_ok(1)) begin
      gie_q <= avs_writedata[GC_GIE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      psc_sel_q <= PSC_SEL_W'(REG8_RST);
    end else if (wr_go && reg_hit(OFS_PSC_SEL) && lane_ok(0)) begin
      psc_sel_q <= avs_writedata[PSC_SEL_W-1:0];
    end
  end

  // unimplemented control bits 6..3 stay zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tba_ctrl_q <= REG8_RST;
      tbb_ctrl_q <= REG8_RST;
    end else if (wr_go && lane_ok(0)) begin
      if (reg_hit(OFS_TBA_CTRL)) begin
        tba_ctrl_q <= {avs_writedata[TB_ON_BIT], 4'h0, avs_writedata[TB_PER_W-1:0]};
      end
      if (reg_hit(OFS_TBB_CTRL)) begin
        tbb_ctrl_q <= {avs_writedata[TB_ON_BIT], 4'h0, avs_writedata[TB_PER_W-1:0]};
      end
    end
  end

  // a group is pending when its group flag and enable are set and a member is both flagged and enabled
  always_comb begin
    for (int g = 0; g < N_GRP; g++) begin
      grp_pend[g] = grp_flag_q[g] && grp_en_q[g] &&
                    (|(src_flag_q & src_en_q & GRP_MASK[g]));
    end
  end

  // lowest group number has priority
  always_comb begin
    sel_grp = vector_group;
    for (int g = N_GRP - 1; g >= 0; g--) begin
      if (grp_pend[g]) begin
        sel_grp = 2'(g);
      end
    end
  end

  // vector_group stays stable through the ack cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vector_req   <= 1'b0;
      vector_group <= 2'h0;
    end else begin
      vector_req <= gie_q && !stack_full && !vector_ack && (|grp_pend);
      if (!vector_ack) begin
        vector_group <= sel_grp;
      end
    end
  end

  // sticky status per group flag set; read clears, new set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_q <= GRP_RST;
    end else if (rd_go && reg_hit(OFS_IRQ_STAT)) begin
      stat_q <= grp_set;
    end else begin
      stat_q <= stat_q | grp_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_q <= GRP_RST;
    end else if (wr_go && reg_hit(OFS_IRQ_MASK) && lane_ok(0)) begin
      mask_q <= avs_writedata[N_GRP-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

endmodule

`default_nettype wire

// ---- sim/mfirq_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module mfirq_sva
  import mfirq_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              stack_full,
  input wire logic              vector_ack,
  input wire logic              return_enable,
  input wire logic              vector_req,
  input wire logic [1:0]        vector_group,
  input wire logic              irq
);
  logic rd_done;
  assign rd_done = avs_read && !avs_waitrequest;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus request answered without wait state");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  // reset must hold vector_req, irq and avs_readdata low, not only the internal state
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !vector_req && !irq && avs_readdata == 32'h0)
    else $error("output active during reset");
  a_stack_block: assert property (stack_full |=> !vector_req)
    else $error("vector request while stack full");
  a_ack_drop: assert property (vector_ack |=> !vector_req)
    else $error("vector request kept after service");
  a_ack_gie_off: assert property (
    vector_ack ##1 (!return_enable && !avs_write) [*4] |-> !vector_req)
    else $error("global enable not cleared by service");
  a_psc_upper: assert property (
    rd_done && avs_address == OFS_PSC_SEL |-> avs_readdata[31:2] == '0)
    else $error("prescaler select upper bits not zero");
  a_tb_gap: assert property (rd_done
    && (avs_address == OFS_TBA_CTRL || avs_address == OFS_TBB_CTRL)
    |-> avs_readdata[31:8] == '0 && avs_readdata[6:3] == '0)
    else $error("time base control gap bits not zero");
  a_src_width: assert property (
    rd_done && avs_address == OFS_SRC_FLAG |-> avs_readdata[31:14] == '0)
    else $error("source flag register too wide");
  a_unmapped_zero: assert property (rd_done && avs_address[5] |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (vector_ack && vector_group == 2'h3);
  cover property (rd_done && avs_address == OFS_IRQ_STAT && avs_readdata != 32'h0);
  cover property (stack_full && !vector_req ##1 !stack_full ##1 vector_req);
endmodule
bind mfirq_top mfirq_sva mfirq_sva_inst (.clk_sys, .rst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .stack_full, .vector_ack,
  .return_enable, .vector_req, .vector_group, .irq);
`default_nettype wire

// ---- sim/tb_multifunction_irq_sources.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_multifunction_irq_sources
  import mfirq_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [N_OVP-1:0]  overvolt_cmp = '0;
  logic              jitter_counter_ovf = 1'b0;
  logic              approach_done = 1'b0;
  logic [N_TMEV-1:0] tm_match = '0;
  logic              pwm_period_match = 1'b0;
  logic              pwm_duty_match = 1'b0;
  logic              subsidiary_clock = 1'b0;
  logic              stack_full = 1'b0;
  logic              vector_ack = 1'b0;
  logic              return_enable = 1'b0;
  logic              vector_req;
  logic [1:0]        vector_group;
  logic              irq;
  logic [31:0]       exp_q[$];
  logic [15:0]       seed = 16'h0f86;
  logic [13:0]       m;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cyc = 0;

  mfirq_top mfirq_top_inst (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .overvolt_cmp, .jitter_counter_ovf, .approach_done, .tm_match, .pwm_period_match,
    .pwm_duty_match, .subsidiary_clock, .stack_full, .vector_ack, .return_enable,
    .vector_req, .vector_group, .irq);

  always #25 clk_sys = ~clk_sys;

  // slow clock of 10 cycles so the 1x select is clearly apart from the others
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0) subsidiary_clock <= ~subsidiary_clock;
    if (cyc == 15000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      stop_test();
    end
  end

  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0) begin
      tests_run++;
      if (exp_q.size() == 0 || avs_readdata !== exp_q.pop_front()) begin
        error_cnt++;
        $display("[ERR] %0t read data %0h unexpected", $time, avs_readdata);
      end
    end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t core output %0h expected %0h", $time, got, exp);
    end
  endtask

  // idle edge after release so a strobe never drops and rises in one step
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic ev(input logic [13:0] v);
    overvolt_cmp <= v[3:0];
    jitter_counter_ovf <= v[SRC_JIT_OVF];
    approach_done <= v[SRC_APPR];
    tm_match <= v[9:6];
    pwm_period_match <= v[SRC_PWM_PER];
    pwm_duty_match <= v[SRC_PWM_DTY];
    @(posedge clk_sys);
    {overvolt_cmp, jitter_counter_ovf, approach_done, tm_match} <= '0;
    {pwm_period_match, pwm_duty_match} <= '0;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic tbt(input logic [5:0] a, input logic [1:0] s, input logic [7:0] c,
                     input int b, input int lo, input int hi);
    wr(OFS_SRC_FLAG, 32'h0);
    wr(OFS_PSC_SEL, {30'h0, s});
    wr(a, {24'h0, c});
    repeat (lo) @(posedge clk_sys);
    rd(OFS_SRC_FLAG, 32'h0);
    repeat (hi - lo) @(posedge clk_sys);
    rd(OFS_SRC_FLAG, 32'h1 << b);
    wr(a, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(6'(i * 4), 32'h0);
    wr(6'h20, 32'hffff_ffff);
    rd(6'h20, 32'h0);
    // a write with its lane disabled must leave the field alone
    avs_byteenable <= 4'h2;
    wr(OFS_PSC_SEL, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    rd(OFS_PSC_SEL, 32'h0);
    wr(OFS_PSC_SEL, 32'hffff_ffff);
    rd(OFS_PSC_SEL, 32'h3);
    wr(OFS_TBA_CTRL, 32'hffff_ffff);
    rd(OFS_TBA_CTRL, 32'h87);
    wr(OFS_TBA_CTRL, 32'h0);
    seed = lfsr(seed);
    m = (seed[13:0] & 14'h0fff) | 14'h0451;
    wr(OFS_SRC_EN, 32'h3fff);
    wr(OFS_IRQ_MASK, 32'hf);
    wr(OFS_GRP_CTRL, 32'hf);
    stack_full <= 1'b1;
    ev(m);
    rd(OFS_SRC_FLAG, {18'h0, m});
    rd(OFS_GRP_CTRL, 32'hff);
    chk(irq, 2'h1);
    rd(OFS_IRQ_STAT, 32'hf);
    rd(OFS_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk(irq, 2'h0);
    wr(OFS_GRP_CTRL, 32'h1ff);
    repeat (3) @(posedge clk_sys);
    chk(vector_req, 2'h0);
    stack_full <= 1'b0;
    for (int g = 0; g < 4; g++) begin
      repeat (3) @(posedge clk_sys);
      chk(vector_req, 2'h1);
      chk(vector_group, g[1:0]);
      vector_ack <= 1'b1;
      @(posedge clk_sys);
      vector_ack <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk(vector_req, 2'h0);
      return_enable <= 1'b1;
      @(posedge clk_sys);
      return_enable <= 1'b0;
    end
    rd(OFS_SRC_FLAG, {18'h0, m});
    rd(OFS_GRP_CTRL, 32'h10f);
    wr(OFS_GRP_CTRL, 32'h0);
    tbt(OFS_TBA_CTRL, 2'h0, 8'h80, SRC_TBA, 240, 280);
    tbt(OFS_TBB_CTRL, 2'h0, 8'h81, SRC_TBB, 490, 540);
    tbt(OFS_TBB_CTRL, 2'h1, 8'h80, SRC_TBB, 1000, 1050);
    tbt(OFS_TBA_CTRL, 2'h2, 8'h80, SRC_TBA, 2400, 2700);
    tbt(OFS_TBB_CTRL, 2'h3, 8'h80, SRC_TBB, 2400, 2700);
    // service the time base group; its source flag must survive
    wr(OFS_GRP_CTRL, 32'h188);
    repeat (3) @(posedge clk_sys);
    chk(vector_req, 2'h1);
    chk(vector_group, 2'h3);
    vector_ack <= 1'b1;
    @(posedge clk_sys);
    vector_ack <= 1'b0;
    rd(OFS_SRC_FLAG, 32'h1 << SRC_TBB);
    rd(OFS_GRP_CTRL, 32'h8);
    wr(OFS_SRC_FLAG, 32'h0);
    rd(OFS_SRC_FLAG, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
